// ==== src/gcrfmt_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcrfmt_consts.svh"

module gcrfmt_top
	import gcrfmt_pkg::*;
#(
	parameter logic [7:0]  SYNC_SUBGROUPS = `GCRFMT_SYNC_SUBS,
	parameter logic [15:0] RESYNC_GROUPS  = `GCRFMT_RESYNC_GRPS,
	parameter logic [7:0]  PE_PRE_LEN     = `GCRFMT_PE_PRE_LEN,
	parameter logic [7:0]  PE_POST_LEN    = `GCRFMT_PE_POST_LEN,
	parameter logic [7:0]  ARA_LEN        = `GCRFMT_ARA_LEN,
	parameter logic [7:0]  ARAID_SUBS     = `GCRFMT_ARAID_SUBS
) (
	// clock and reset
	input  wire logic                       CLOCK_I,
	input  wire logic                       RESET_I,
	// block requests
	input  wire logic                       PE_MODE_I,
	input  wire logic                       ARA_REQ_I,
	// upstream bytes
	input  wire logic [7:0]                 DATA_I,
	input  wire logic                       DATA_VALID_I,
	input  wire logic                       DATA_LAST_I,
	output logic                            DATA_READY_O,
	// write channel
	output logic [`GCRFMT_TRACKS-1:0]       WR_CHAR_O,
	output logic                            WR_VALID_O,
	input  wire logic                       WR_READY_I,
	// status
	output logic                            BUSY_O,
	output logic                            BLOCK_DONE_O
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	// odd byte parity sits on track four
	function automatic gcrfmt_char_t to_char(input logic [7:0] b);
		to_char = {b[7:3], ~^b, b[2:0]};
	endfunction : to_char

	// pads unused slots, places position seven, builds the check char
	function automatic gcrfmt_grp_t seal(input gcrfmt_grp_t g, input logic [2:0] k,
		input gcrfmt_char_t c6);
		gcrfmt_grp_t  o;
		gcrfmt_char_t x;
		o = g;
		x = '0;
		for (int i = 0; i < `GCRFMT_GRP_CHARS - 2; i++) begin
			if (3'(i) >= k) begin
				o[i] = to_char(`GCRFMT_PAD_BYTE);
			end
		end
		o[`GCRFMT_RES_POS] = c6;
		for (int i = 0; i < `GCRFMT_GRP_CHARS - 1; i++) begin
			x = x ^ o[i];
		end
		// xor of seven odd characters keeps track four odd
		o[`GCRFMT_ECC_POS] = x;
		seal = o;
	endfunction : seal

	function automatic logic [4:0] pattern(input gcrfmt_kind_t k);
		unique case (k)
			k_term:   pattern = `GCRFMT_PAT_TERM;
			k_last:   pattern = `GCRFMT_PAT_TERM;
			k_second: pattern = `GCRFMT_PAT_SECOND;
			k_sync:   pattern = `GCRFMT_PAT_SYNC;
			k_mark1:  pattern = `GCRFMT_PAT_MARK1;
			k_mark2:  pattern = `GCRFMT_PAT_MARK2;
			k_endm:   pattern = `GCRFMT_PAT_ENDM;
			k_araid:  pattern = `GCRFMT_PAT_ARAID;
			default:  pattern = `GCRFMT_PAT_SYNC;
		endcase
	endfunction : pattern

	// record tail order
	function automatic gcrfmt_kind_t trail_kind(input logic [7:0] s);
		unique case (s)
			8'h00:   trail_kind = k_endm;
			8'h01:   trail_kind = k_data_a;
			8'h02:   trail_kind = k_data_b;
			8'h03:   trail_kind = k_data_a;
			8'h04:   trail_kind = k_data_b;
			8'h05:   trail_kind = k_mark2;
			8'h06:   trail_kind = k_sync;
			8'h07:   trail_kind = k_second;
			default: trail_kind = k_last;
		endcase
	endfunction : trail_kind

	// ****************************************************************
	// state
	// ****************************************************************
	gcrfmt_regs_t                                    r;
	gcrfmt_regs_t                                    n;
	logic         [`GCRFMT_TRACKS-1:0][3:0]          nib;
	logic         [`GCRFMT_TRACKS-1:0][4:0]          codes;
	gcrfmt_char_t                                    data_ch;
	gcrfmt_char_t                                    ctrl_ch;
	gcrfmt_char_t                                    echar;
	gcrfmt_char_t                                    byte_c;
	gcrfmt_grp_t                                     g;
	logic         [4:0]                              pat;
	logic         [7:0]                              crc_c;
	logic         [7:0]                              aux_c;
	logic         [2:0]                              bitpos;
	logic                                            is_data;
	logic                                            half;
	logic                                            emit_ok;
	logic                                            do_emit;
	logic                                            ectrl;
	logic                                            sub_done;
	logic                                            accept;
	logic                                            sub_state;

	// ****************************************************************
	// per track translation
	// ****************************************************************
	assign is_data = (r.kind == k_data_a) || (r.kind == k_data_b);
	assign half    = (r.kind == k_data_b);
	assign bitpos  = `GCRFMT_LAST_CIDX - r.cidx;

	always_comb begin
		for (int t = 0; t < `GCRFMT_TRACKS; t++) begin
			for (int j = 0; j < `GCRFMT_NIB_BITS; j++) begin
				nib[t][3-j] = r.grp[{half, 2'(j)}][t];
			end
		end
	end

	for (genvar t = 0; t < `GCRFMT_TRACKS; t++) begin : g_trk
		gcrfmt_enc u_enc (
			.nibble_i (nib[t]),
			.code_o   (codes[t])
		);
	end

	always_comb begin
		pat = pattern(r.kind);
		for (int t = 0; t < `GCRFMT_TRACKS; t++) begin
			data_ch[t] = codes[t][bitpos];
		end
		ctrl_ch = {`GCRFMT_TRACKS{pat[bitpos]}};
		if ((r.kind == k_last) && (r.cidx == `GCRFMT_LAST_CIDX)) begin
			ctrl_ch = `GCRFMT_ERASE_CHAR;
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		n         = r;
		n.done    = 1'b0;
		emit_ok   = !r.out_valid || WR_READY_I;
		sub_state = (r.st == st_lead) || (r.st == st_group) || (r.st == st_trail) ||
			(r.st == st_ara_id);
		do_emit   = sub_state && emit_ok;
		echar     = is_data ? data_ch : ctrl_ch;
		ectrl     = !is_data;
		sub_done  = emit_ok && (r.cidx == `GCRFMT_LAST_CIDX);
		accept    = DATA_VALID_I && r.rdy;
		byte_c    = to_char(DATA_I);
		crc_c     = {r.crc[6:0], r.crc[7]} ^ DATA_I;
		aux_c     = r.aux + DATA_I;
		g         = r.grp;
		if (WR_READY_I) begin
			n.out_valid = 1'b0;
		end
		if (do_emit) begin
			n.cidx = sub_done ? 3'h0 : r.cidx + 3'h1;
		end
		unique case (r.st)
			st_idle: begin
				n.busy = 1'b0;
				n.cidx = 3'h0;
				n.step = 8'h00;
				if (ARA_REQ_I) begin
					n.st   = st_ara;
					n.busy = 1'b1;
				end else if (DATA_VALID_I) begin
					n.busy      = 1'b1;
					n.cnt       = 16'h0000;
					n.crc       = 8'h00;
					n.aux       = 8'h00;
					n.fill      = 3'h0;
					n.rmod      = 3'h0;
					n.gcount    = 16'h0000;
					n.last_seen = 1'b0;
					n.kind      = k_term;
					n.st        = PE_MODE_I ? st_pe_pre : st_lead;
				end
			end
			st_ara: begin
				do_emit = emit_ok;
				echar   = `GCRFMT_ARA_CHAR;
				ectrl   = 1'b1;
				if (emit_ok) begin
					n.step = r.step + 8'h01;
					if (r.step == ARA_LEN - 8'h01) begin
						n.st   = st_ara_id;
						n.kind = k_araid;
						n.step = 8'h00;
						n.cidx = 3'h0;
					end
				end
			end
			st_ara_id: begin
				if (sub_done) begin
					n.step = r.step + 8'h01;
					if (r.step == ARAID_SUBS - 8'h01) begin
						n.st   = st_idle;
						n.done = 1'b1;
					end
				end
			end
			st_pe_pre: begin
				do_emit = emit_ok;
				echar   = `GCRFMT_PE_PRE_CHAR;
				ectrl   = 1'b0;
				if (emit_ok) begin
					n.step = r.step + 8'h01;
					if (r.step == PE_PRE_LEN - 8'h01) begin
						n.st   = st_pe_data;
						n.step = 8'h00;
					end
				end
			end
			st_pe_data: begin
				echar = byte_c;
				ectrl = 1'b0;
				if (accept) begin
					do_emit = 1'b1;
					n.cnt   = r.cnt + 16'h0001;
					if (DATA_LAST_I) begin
						n.st = st_pe_post;
					end
				end
			end
			st_pe_post: begin
				do_emit = emit_ok;
				echar   = `GCRFMT_PE_POST_CHAR;
				ectrl   = 1'b0;
				if (emit_ok) begin
					n.step = r.step + 8'h01;
					if (r.step == PE_POST_LEN - 8'h01) begin
						n.st   = st_idle;
						n.done = 1'b1;
					end
				end
			end
			st_lead: begin
				if (sub_done) begin
					unique case (r.kind)
						k_term:   n.kind = k_second;
						k_second: begin
							n.kind = k_sync;
							n.step = 8'h00;
						end
						k_mark2: begin
							n.kind = k_sync;
							n.step = 8'h00;
						end
						k_sync: begin
							n.step = r.step + 8'h01;
							if (r.step == SYNC_SUBGROUPS - 8'h01) begin
								n.kind = k_mark1;
							end
						end
						k_mark1: begin
							n.st   = st_fill;
							n.fill = 3'h0;
						end
						default: n.st = st_idle;
					endcase
				end
			end
			st_fill: begin
				if (accept) begin
					n.cnt       = r.cnt + 16'h0001;
					n.crc       = crc_c;
					n.aux       = aux_c;
					g[r.fill]   = byte_c;
					if (r.fill == `GCRFMT_DATA_LAST) begin
						n.grp       = seal(g, `GCRFMT_RES_POS, g[`GCRFMT_RES_POS]);
						n.st        = st_group;
						n.kind      = k_data_a;
						n.cidx      = 3'h0;
						n.fill      = 3'h0;
						n.rmod      = 3'h0;
						n.last_seen = DATA_LAST_I;
					end else if (DATA_LAST_I) begin
						n.grp  = seal(g, r.fill + 3'h1, to_char(aux_c));
						n.rmod = r.fill + 3'h1;
						n.st   = st_trail;
						n.kind = k_endm;
						n.step = 8'h00;
						n.cidx = 3'h0;
					end else begin
						n.grp  = g;
						n.fill = r.fill + 3'h1;
					end
				end
			end
			st_group: begin
				if (sub_done) begin
					if (r.kind == k_data_a) begin
						n.kind = k_data_b;
					end else if (r.last_seen) begin
						n.grp  = seal(r.grp, 3'h0, to_char(r.aux));
						n.st   = st_trail;
						n.kind = k_endm;
						n.step = 8'h00;
					end else if (r.gcount == RESYNC_GROUPS - 16'h0001) begin
						n.gcount = 16'h0000;
						n.st     = st_lead;
						n.kind   = k_mark2;
					end else begin
						n.gcount = r.gcount + 16'h0001;
						n.st     = st_fill;
					end
				end
			end
			st_trail: begin
				if (sub_done) begin
					n.step = r.step + 8'h01;
					n.kind = trail_kind(r.step + 8'h01);
					if (r.step == 8'h02) begin
						g[0]  = to_char(r.crc);
						n.grp = seal(g, 3'h1, to_char({r.rmod, r.cnt[4:0]}));
					end
					if (r.kind == k_last) begin
						n.st   = st_idle;
						n.done = 1'b1;
					end
				end
			end
		endcase
		if (do_emit) begin
			n.out_char  = echar;
			n.out_valid = 1'b1;
			n.out_ctrl  = ectrl;
		end
		n.rdy = (n.st == st_fill) || ((n.st == st_pe_data) && !n.out_valid);
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign DATA_READY_O = r.rdy;
	assign WR_CHAR_O    = r.out_char;
	assign WR_VALID_O   = r.out_valid;
	assign BUSY_O       = r.busy;
	assign BLOCK_DONE_O = r.done;

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_group_seven_bytes: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_group) && ($past(r.st) == st_fill) |-> ($past(r.fill) == `GCRFMT_DATA_LAST))
		else $error("data group left fill before seven bytes");

	chk_halves_ten_chars: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_group) && (r.kind == k_data_a) && (r.cidx == 3'h0) && emit_ok
		##1 (emit_ok && (r.cidx != 3'h0)) [*4] |=> (r.kind == k_data_b) && (r.cidx == 3'h0))
		else $error("storage subgroup not five characters");

	chk_code_density: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		is_data |-> ($countones(codes[0]) >= 2) && (codes[0][4:3] != 2'b00) &&
		(codes[0][1:0] != 2'b00))
		else $error("record code has too few ones");

	chk_resid_char: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_trail) && (r.step == 8'h03) && (r.cidx == 3'h0)
		|-> (r.grp[`GCRFMT_RES_POS] == to_char({r.rmod, r.cnt[4:0]})))
		else $error("residual character wrong in crc group");

	chk_endmark_first: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		$rose(r.st == st_trail) |-> (r.kind == k_endm) && (r.cidx == 3'h0))
		else $error("tail did not open with end mark");

	chk_term_opens: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_lead) && ($past(r.st) == st_idle) |-> (r.kind == k_term))
		else $error("record did not open with terminator");

	chk_last_erase: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		r.done && ($past(r.st) == st_trail) |-> r.out_valid && (r.out_char == `GCRFMT_ERASE_CHAR))
		else $error("block did not end at erase level");

	chk_ctrl_uniform: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		r.out_valid && r.out_ctrl |-> (r.out_char == '0) || (r.out_char == '1))
		else $error("control character differs between tracks");

	chk_mark1_before: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_fill) && ($past(r.st) == st_lead) |-> ($past(r.kind) == k_mark1))
		else $error("data began without mark 1");

	chk_pe_frame: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		(r.st == st_pe_data) && ($past(r.st) == st_pe_pre) |-> ($past(r.step) == PE_PRE_LEN - 8'h01))
		else $error("phase encoded preamble length wrong");

	chk_ready_safe: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		r.rdy && (r.st == st_pe_data) |-> !r.out_valid)
		else $error("byte offered while write slot occupied");

endmodule : gcrfmt_top
`default_nettype wire

// ==== shared/gcrfmt_consts.svh ====
`ifndef GCRFMT_CONSTS_SVH
`define GCRFMT_CONSTS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define GCRFMT_TRACKS       9
`define GCRFMT_GRP_CHARS    8
`define GCRFMT_NIB_BITS     4
`define GCRFMT_CODE_BITS    5
`define GCRFMT_DATA_LAST    3'h6
`define GCRFMT_RES_POS      3'h6
`define GCRFMT_ECC_POS      3'h7
`define GCRFMT_LAST_CIDX    3'h4
`define GCRFMT_PAD_BYTE     8'h00

// ****************************************************************
// control patterns, serial per track (arbitrary but distinct)
// ****************************************************************
`define GCRFMT_PAT_TERM     5'h15
`define GCRFMT_PAT_SECOND   5'h1B
`define GCRFMT_PAT_SYNC     5'h1F
`define GCRFMT_PAT_MARK1    5'h13
`define GCRFMT_PAT_MARK2    5'h19
`define GCRFMT_PAT_ENDM     5'h17
`define GCRFMT_PAT_ARAID    5'h1D

// ****************************************************************
// fixed characters and default counts
// ****************************************************************
`define GCRFMT_ERASE_CHAR   9'h000
`define GCRFMT_ARA_CHAR     9'h1FF
`define GCRFMT_PE_PRE_CHAR  9'h000
`define GCRFMT_PE_POST_CHAR 9'h000
`define GCRFMT_SYNC_SUBS    8'h04
`define GCRFMT_RESYNC_GRPS  16'h0010
`define GCRFMT_PE_PRE_LEN   8'h28
`define GCRFMT_PE_POST_LEN  8'h28
`define GCRFMT_ARA_LEN      8'h40
`define GCRFMT_ARAID_SUBS   8'h04

`endif

// ==== shared/gcrfmt_pkg.sv ====
`include "gcrfmt_consts.svh"

package gcrfmt_pkg;

	typedef enum logic [3:0] {
		st_idle, st_ara, st_ara_id, st_pe_pre, st_pe_data, st_pe_post,
		st_lead, st_fill, st_group, st_trail
	} gcrfmt_state_t;

	typedef enum logic [3:0] {
		k_term, k_second, k_sync, k_mark1, k_mark2, k_endm, k_araid, k_last,
		k_data_a, k_data_b
	} gcrfmt_kind_t;

	typedef logic [`GCRFMT_TRACKS-1:0] gcrfmt_char_t;
	typedef gcrfmt_char_t [`GCRFMT_GRP_CHARS-1:0] gcrfmt_grp_t;

	typedef struct packed {
		gcrfmt_state_t st;
		gcrfmt_kind_t  kind;
		logic [2:0]    cidx;
		logic [7:0]    step;
		logic [15:0]   gcount;
		logic [15:0]   cnt;
		logic [2:0]    fill;
		logic [2:0]    rmod;
		gcrfmt_grp_t   grp;
		logic [7:0]    crc;
		logic [7:0]    aux;
		logic          last_seen;
		gcrfmt_char_t  out_char;
		logic          out_valid;
		logic          out_ctrl;
		logic          rdy;
		logic          busy;
		logic          done;
	} gcrfmt_regs_t;

endpackage : gcrfmt_pkg

// ==== src/gcrfmt_enc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcrfmt_consts.svh"

module gcrfmt_enc (
	// data nibble of one track
	input  wire logic [`GCRFMT_NIB_BITS-1:0]  nibble_i,
	// record code of the same track
	output logic      [`GCRFMT_CODE_BITS-1:0] code_o
);

	// ****************************************************************
	// record code table
	// ****************************************************************
	always_comb begin
		unique case (nibble_i)
			4'h0: code_o = 5'h19;
			4'h1: code_o = 5'h1B;
			4'h2: code_o = 5'h12;
			4'h3: code_o = 5'h13;
			4'h4: code_o = 5'h1D;
			4'h5: code_o = 5'h15;
			4'h6: code_o = 5'h16;
			4'h7: code_o = 5'h17;
			4'h8: code_o = 5'h1A;
			4'h9: code_o = 5'h09;
			4'hA: code_o = 5'h0A;
			4'hB: code_o = 5'h0B;
			4'hC: code_o = 5'h1E;
			4'hD: code_o = 5'h0D;
			4'hE: code_o = 5'h0E;
			4'hF: code_o = 5'h0F;
		endcase
	end

endmodule : gcrfmt_enc
`default_nettype wire

// ==== verif/gcrfmt_wr_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module gcrfmt_wr_model
	import gcrfmt_pkg::*;
(
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	// write channel
	input  wire gcrfmt_char_t wr_char_i,
	input  wire logic         wr_valid_i,
	output logic              wr_ready_o,
	// stall control
	input  wire logic         slow_i
);
	// ****************************************************************
	// channel: takes one character on each edge with valid and ready
	// ****************************************************************
	gcrfmt_char_t got[$];
	logic [1:0]   cnt_r = 2'h0;

	initial begin
		wr_ready_o = 1'b0;
	end

	// slow mode accepts one edge in four, so held characters get exercised
	always @(posedge clock_i) begin
		if (wr_valid_i && wr_ready_o && !reset_i) begin
			got.push_back(wr_char_i);
		end
		cnt_r <= cnt_r + 2'h1;
		#1 wr_ready_o = !reset_i && (!slow_i || cnt_r == 2'h0);
	end
endmodule : gcrfmt_wr_model

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gcrfmt_consts.svh"

module tb;
	import gcrfmt_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         pe_mode = 1'b0;
	logic         ara_req = 1'b0;
	logic [7:0]   dbyte = 8'h00;
	logic         dvalid = 1'b0;
	logic         dlast = 1'b0;
	logic         slow = 1'b0;
	logic         dready;
	gcrfmt_char_t wchar;
	logic         wvalid;
	logic         wready;
	logic         busy;
	logic         done;
	int           failures = 0;
	int           tests_run = 0;
	gcrfmt_char_t exp_q[$];
	bit           care_q[$];
	int           done_cnt = 0;

	localparam logic [4:0] term_pat = `GCRFMT_PAT_TERM;

	always #10 clk = ~clk;

	// done is a one-cycle pulse, so one count per pulse
	always @(posedge clk) begin
		if (done === 1'b1) done_cnt++;
	end

	gcrfmt_top #(
		.SYNC_SUBGROUPS(8'h04), .RESYNC_GROUPS(16'h0002), .PE_PRE_LEN(8'h03),
		.PE_POST_LEN(8'h03), .ARA_LEN(8'h04)
	) i_dut (
		.CLOCK_I(clk), .RESET_I(rst), .PE_MODE_I(pe_mode), .ARA_REQ_I(ara_req),
		.DATA_I(dbyte), .DATA_VALID_I(dvalid), .DATA_LAST_I(dlast),
		.DATA_READY_O(dready), .WR_CHAR_O(wchar), .WR_VALID_O(wvalid),
		.WR_READY_I(wready), .BUSY_O(busy), .BLOCK_DONE_O(done)
	);

	gcrfmt_wr_model i_chan (
		.clock_i(clk), .reset_i(rst), .wr_char_i(wchar), .wr_valid_i(wvalid),
		.wr_ready_o(wready), .slow_i(slow)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	task fail(input string m);
		failures++;
		$display("FAIL %0t %s", $time, m);
	endtask : fail

	function logic [4:0] rec(input logic [3:0] n);
		logic [4:0] t [16];
		t = '{5'h19, 5'h1B, 5'h12, 5'h13, 5'h1D, 5'h15, 5'h16, 5'h17,
			5'h1A, 5'h09, 5'h0A, 5'h0B, 5'h1E, 5'h0D, 5'h0E, 5'h0F};
		return t[n];
	endfunction : rec

	// only 00 and ff bytes, so every data track except parity track four carries the same nibble
	function logic [7:0] bval(input int i);
		return (i % 3 == 0) ? 8'hFF : 8'h00;
	endfunction : bval

	function gcrfmt_char_t dchar(input logic [7:0] b);
		return (b == 8'hFF) ? 9'h1FF : 9'h008;
	endfunction : dchar

	task push_char(input gcrfmt_char_t c, input bit k);
		exp_q.push_back(c);
		care_q.push_back(k);
	endtask : push_char

	task push_sub(input logic [4:0] p);
		for (int j = 0; j < 5; j++) push_char({9{p[4-j]}}, 1'b1);
	endtask : push_sub

	task push_grp(input int g);
		logic [7:0]   x;
		gcrfmt_char_t c [8];
		logic [4:0]   code;
		gcrfmt_char_t o;
		x = 8'h00;
		for (int p = 0; p < 7; p++) begin
			c[p] = dchar(bval(7 * g + p));
			x = x ^ bval(7 * g + p);
		end
		c[7] = dchar(x);
		for (int h = 0; h < 2; h++) begin
			for (int j = 0; j < 5; j++) begin
				for (int t = 0; t < 9; t++) begin
					code = rec({c[4*h][t], c[4*h+1][t], c[4*h+2][t], c[4*h+3][t]});
					o[t] = code[4-j];
				end
				push_char(o, 1'b1);
			end
		end
	endtask : push_grp

	task send(input int n);
		int w;
		for (int i = 0; i < n; i++) begin
			dbyte = bval(i);
			dlast = (i == n - 1);
			dvalid = 1'b1;
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (dready !== 1'b1 && w < 2000);
			if (w >= 2000) fail("byte not taken");
			#1;
		end
		dvalid = 1'b0;
		dlast = 1'b0;
	endtask : send

	task check_blk(input string name);
		int w;
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while ((busy !== 1'b0 || wvalid !== 1'b0) && w < 4000);
		#1;
		tests_run++;
		if (w >= 4000) fail("block never ended");
		if (i_chan.got.size() != exp_q.size()) fail("character count wrong");
		for (int i = 0; i < exp_q.size() && i < i_chan.got.size(); i++) begin
			if (care_q[i] && i_chan.got[i] !== exp_q[i]) fail("character wrong");
		end
		if (done_cnt != 1) fail("block done pulse count wrong");
		$display("test %s done", name);
		exp_q.delete();
		care_q.delete();
		i_chan.got.delete();
		done_cnt = 0;
	endtask : check_blk

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task test_gcr(input int n, input bit stall, input string name);
		slow = stall;
		pe_mode = 1'b0;
		push_sub(`GCRFMT_PAT_TERM);
		push_sub(`GCRFMT_PAT_SECOND);
		for (int s = 0; s < 4; s++) push_sub(`GCRFMT_PAT_SYNC);
		push_sub(`GCRFMT_PAT_MARK1);
		for (int g = 0; g < n / 7; g++) begin
			if (g > 0 && g % 2 == 0) begin
				push_sub(`GCRFMT_PAT_MARK2);
				for (int s = 0; s < 4; s++) push_sub(`GCRFMT_PAT_SYNC);
				push_sub(`GCRFMT_PAT_MARK1);
			end
			push_grp(g);
		end
		push_sub(`GCRFMT_PAT_ENDM);
		for (int i = 0; i < 20; i++) push_char(9'h000, 1'b0);
		push_sub(`GCRFMT_PAT_MARK2);
		// the record tail carries a single sync subgroup
		push_sub(`GCRFMT_PAT_SYNC);
		push_sub(`GCRFMT_PAT_SECOND);
		for (int j = 0; j < 4; j++) push_char({9{term_pat[4-j]}}, 1'b1);
		push_char(`GCRFMT_ERASE_CHAR, 1'b1);
		send(n);
		check_blk(name);
		slow = 1'b0;
	endtask : test_gcr

	task test_pe;
		pe_mode = 1'b1;
		for (int i = 0; i < 3; i++) push_char(9'h000, 1'b1);
		for (int i = 0; i < 2; i++) push_char(dchar(bval(i)), 1'b1);
		for (int i = 0; i < 3; i++) push_char(9'h000, 1'b1);
		send(2);
		check_blk("pe_block");
		pe_mode = 1'b0;
	endtask : test_pe

	task test_ara;
		int w;
		for (int i = 0; i < 4; i++) push_char(`GCRFMT_ARA_CHAR, 1'b1);
		for (int s = 0; s < 4; s++) push_sub(`GCRFMT_PAT_ARAID);
		ara_req = 1'b1;
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while (busy !== 1'b1 && w < 100);
		#1 ara_req = 1'b0;
		check_blk("ara_burst");
	endtask : test_ara

	task results;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	initial begin
		// the four blocks need well under two thousand cycles
		#400000;
		failures++;
		results();
	end

	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk);
		#1;
		test_gcr(21, 1'b1, "gcr_three_groups_stalled");
		test_gcr(10, 1'b0, "gcr_with_residual");
		test_pe();
		test_ara();
		results();
	end
endmodule : tb

`default_nettype wire
